// ==== inc/ssswp_pkg.sv ====
// constants and types for the subtract, skip and swap datapath
package ssswp_pkg;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned FLAG_W = 6;
   // positions of the status flags in the flag vector
   localparam int unsigned FLG_CARRY = 0;
   localparam int unsigned FLG_AUX = 1;
   localparam int unsigned FLG_ZERO = 2;
   localparam int unsigned FLG_OVF = 3;
   localparam int unsigned FLG_SCMP = 4;
   localparam int unsigned FLG_CZERO = 5;
   // reset values
   localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_RST = 8'h00;
   localparam logic [FLAG_W-1:0] FLAG_RST = 6'h00;
   localparam logic [1:0] SYNC_RST = 2'h0;
   // memory read latency and the extra cycle taken by the skip test
   localparam int unsigned RD_LAT_CYC = 1;
   localparam int unsigned SKIP_DUMMY_CYC = 1;

   typedef enum logic [2:0] {
      SSSWP_OP_SKIP_NZ = 3'h0, // skip_if_nonzero_op
      SSSWP_OP_SUB_ACC = 3'h1, // acc - mem into acc
      SSSWP_OP_SUB_MEM = 3'h2, // subtract_to_mem_op
      SSSWP_OP_SUB_IMM = 3'h3, // acc - immediate into acc
      SSSWP_OP_SWAP = 3'h4 // nibble swap in place
   } ssswp_op_t;

   typedef enum logic [3:0] {
      SSSWP_ST_IDLE = 4'h1,
      SSSWP_ST_READ = 4'h2,
      SSSWP_ST_EXEC = 4'h4,
      SSSWP_ST_DUMMY = 4'h8
   } ssswp_state_t;
endpackage : ssswp_pkg

// ==== rtl/ssswp_datapath.sv ====
// subtract, skip-if-nonzero and nibble swap execution datapath
//
// Behaviour
// [RULE1] skip test reads the memory byte and writes the same value back
// [RULE2] skip test requests a skip when the byte is non-zero, else continues
// [RULE3] skip test takes two instruction cycles through an inserted dummy cycle
// [RULE4] register subtract loads accumulator minus memory byte into accumulator
// [RULE5] every subtract sets carry on zero or positive difference, clears on negative
// [RULE6] subtracts update all six flags; skip test leaves flags untouched
// [RULE7] subtract-to-memory writes accumulator minus byte back into the memory byte
// [RULE8] immediate subtract loads accumulator minus instruction constant into accumulator
// [RULE9] swap exchanges the low and high nibbles of the memory byte
// [RULE10] swap writes the exchanged byte to the same location without flag changes
// [RULE11] zero on all-zero result, aux on no borrow from bit 3, signed overflow
`timescale 1ns/1ps
`default_nettype none
module ssswp_datapath
   import ssswp_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // instruction request
   input wire logic op_valid,
   input wire ssswp_op_t op_code,
   input wire logic [ADDR_W-1:0] op_addr,
   input wire logic [DATA_W-1:0] op_imm,
   input wire logic [DATA_W-1:0] acc_in,
   output logic op_busy,
   output logic op_done,
   // data memory port
   output logic mem_rd,
   output logic mem_wr,
   output logic [ADDR_W-1:0] mem_addr,
   output logic [DATA_W-1:0] mem_wdata,
   input wire logic [DATA_W-1:0] mem_rdata,
   // accumulator, flags and program counter
   output logic acc_we,
   output logic [DATA_W-1:0] acc_wdata,
   output logic flags_we,
   output logic [FLAG_W-1:0] flags_out,
   output logic skip_req
);
   logic [1:0] sync_q;
   logic rst_sync_n;

   // reset release through two flops
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_q <= SYNC_RST;
      end else begin
         sync_q <= {sync_q[0], 1'b1};
      end
   end
   assign rst_sync_n = sync_q[1];

   ssswp_state_t state_q, state_d;
   ssswp_op_t op_q, op_d;
   logic [DATA_W-1:0] acc_l_q, acc_l_d;
   logic [DATA_W-1:0] imm_q, imm_d;
   logic busy_q, busy_d;
   logic done_q, done_d;
   logic rd_q, rd_d;
   logic wr_q, wr_d;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic [DATA_W-1:0] wdata_q, wdata_d;
   logic acc_we_q, acc_we_d;
   logic [DATA_W-1:0] acc_wdata_q, acc_wdata_d;
   logic flags_we_q, flags_we_d;
   logic [FLAG_W-1:0] flags_q, flags_d;
   logic skip_q, skip_d;

   logic [DATA_W-1:0] opnd;
   logic [DATA_W:0] diff_w;
   logic [4:0] low_w;
   logic [DATA_W-1:0] diff;
   logic ovf;
   logic [FLAG_W-1:0] sub_flags;
   logic [DATA_W-1:0] swapped;

   // subtractor shared by all three subtract forms
   always_comb begin
      opnd = (op_q == SSSWP_OP_SUB_IMM) ? imm_q : mem_rdata; // RULE8
      diff_w = {1'b0, acc_l_q} - {1'b0, opnd};
      low_w = {1'b0, acc_l_q[3:0]} - {1'b0, opnd[3:0]};
      diff = diff_w[DATA_W-1:0];
      ovf = (acc_l_q[7] ^ opnd[7]) & (acc_l_q[7] ^ diff[7]); // RULE11
      sub_flags = FLAG_RST;
      sub_flags[FLG_CARRY] = ~diff_w[DATA_W]; // RULE5
      sub_flags[FLG_AUX] = ~low_w[4]; // RULE11
      sub_flags[FLG_ZERO] = (diff == DATA_RST); // RULE11
      sub_flags[FLG_OVF] = ovf; // RULE11
      sub_flags[FLG_SCMP] = diff[7] ^ ovf;
      sub_flags[FLG_CZERO] = (diff == DATA_RST);
      swapped = {mem_rdata[3:0], mem_rdata[7:4]}; // RULE9
   end

   always_comb begin
      state_d = state_q;
      op_d = op_q;
      acc_l_d = acc_l_q;
      imm_d = imm_q;
      busy_d = busy_q;
      done_d = 1'b0;
      rd_d = 1'b0;
      wr_d = 1'b0;
      addr_d = addr_q;
      wdata_d = wdata_q;
      acc_we_d = 1'b0;
      acc_wdata_d = acc_wdata_q;
      flags_we_d = 1'b0;
      flags_d = flags_q;
      skip_d = 1'b0;
      case (state_q)
         SSSWP_ST_IDLE: begin
            if (op_valid) begin
               op_d = op_code;
               acc_l_d = acc_in;
               imm_d = op_imm;
               addr_d = op_addr;
               busy_d = 1'b1;
               if (op_code == SSSWP_OP_SUB_IMM) begin
                  state_d = SSSWP_ST_EXEC;
               end else begin
                  rd_d = 1'b1;
                  state_d = SSSWP_ST_READ;
               end
            end
         end
         SSSWP_ST_READ: begin
            state_d = SSSWP_ST_EXEC;
         end
         SSSWP_ST_EXEC: begin
            done_d = 1'b1;
            state_d = SSSWP_ST_IDLE;
            busy_d = 1'b0;
            case (op_q)
               SSSWP_OP_SKIP_NZ: begin
                  wr_d = 1'b1; // RULE1
                  wdata_d = mem_rdata; // RULE1
                  skip_d = (mem_rdata != DATA_RST); // RULE2
                  busy_d = 1'b1; // RULE3
                  state_d = SSSWP_ST_DUMMY; // RULE3
               end
               SSSWP_OP_SUB_ACC, SSSWP_OP_SUB_IMM: begin
                  acc_we_d = 1'b1; // RULE4
                  acc_wdata_d = diff; // RULE4
                  flags_we_d = 1'b1; // RULE6
                  flags_d = sub_flags; // RULE6
               end
               SSSWP_OP_SUB_MEM: begin
                  wr_d = 1'b1; // RULE7
                  wdata_d = diff; // RULE7
                  flags_we_d = 1'b1; // RULE6
                  flags_d = sub_flags; // RULE6
               end
               SSSWP_OP_SWAP: begin
                  wr_d = 1'b1; // RULE10
                  wdata_d = swapped; // RULE10
               end
               default: begin
                  done_d = 1'b1;
               end
            endcase
         end
         SSSWP_ST_DUMMY: begin
            busy_d = 1'b0;
            state_d = SSSWP_ST_IDLE;
         end
         default: begin
            state_d = SSSWP_ST_IDLE;
            busy_d = 1'b0;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         state_q <= SSSWP_ST_IDLE;
         op_q <= SSSWP_OP_SKIP_NZ;
         acc_l_q <= DATA_RST;
         imm_q <= DATA_RST;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         rd_q <= 1'b0;
         wr_q <= 1'b0;
         addr_q <= ADDR_RST;
         wdata_q <= DATA_RST;
         acc_we_q <= 1'b0;
         acc_wdata_q <= DATA_RST;
         flags_we_q <= 1'b0;
         flags_q <= FLAG_RST;
         skip_q <= 1'b0;
      end else begin
         state_q <= state_d;
         op_q <= op_d;
         acc_l_q <= acc_l_d;
         imm_q <= imm_d;
         busy_q <= busy_d;
         done_q <= done_d;
         rd_q <= rd_d;
         wr_q <= wr_d;
         addr_q <= addr_d;
         wdata_q <= wdata_d;
         acc_we_q <= acc_we_d;
         acc_wdata_q <= acc_wdata_d;
         flags_we_q <= flags_we_d;
         flags_q <= flags_d;
         skip_q <= skip_d;
      end
   end

   assign op_busy = busy_q;
   assign op_done = done_q;
   assign mem_rd = rd_q;
   assign mem_wr = wr_q;
   assign mem_addr = addr_q;
   assign mem_wdata = wdata_q;
   assign acc_we = acc_we_q;
   assign acc_wdata = acc_wdata_q;
   assign flags_we = flags_we_q;
   assign flags_out = flags_q;
   assign skip_req = skip_q;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_sync_n);

   logic exec_skip, exec_sub;
   assign exec_skip = (state_q == SSSWP_ST_EXEC) && (op_q == SSSWP_OP_SKIP_NZ);
   assign exec_sub = (state_q == SSSWP_ST_EXEC) && (op_q inside
      {SSSWP_OP_SUB_ACC, SSSWP_OP_SUB_MEM, SSSWP_OP_SUB_IMM});

   sequence skip_taken_s;
      state_q == SSSWP_ST_IDLE && op_valid && op_code == SSSWP_OP_SKIP_NZ;
   endsequence
   sequence skip_tail_s;
      // the dummy cycle holds busy through the done cycle, so the next take slips by one
      mem_rd && op_busy ##1 !mem_wr && op_busy ##1 mem_wr && op_done && op_busy
         ##1 !op_busy && !op_done;
   endsequence

   skip_writeback_a: assert property (exec_skip |=> mem_wr && mem_wdata == $past(mem_rdata)
                                                 && mem_addr == $past(addr_q)) // RULE1
      else $error("skip test did not write back the byte it read");
   skip_decision_a: assert property (exec_skip |=> skip_req == ($past(mem_rdata) != 8'h00)) // RULE2
      else $error("skip request does not match the byte tested");
   skip_two_cyc_a: assert property (skip_taken_s |=> skip_tail_s) // RULE3
      else $error("skip test did not take its dummy cycle");
   sub_to_acc_a: assert property (exec_sub && op_q == SSSWP_OP_SUB_ACC
      |=> acc_we && !mem_wr && acc_wdata == $past(acc_l_q) - $past(mem_rdata)) // RULE4
      else $error("register subtract gave a wrong accumulator");
   sub_carry_a: assert property (exec_sub |=> flags_out[FLG_CARRY]
      == ($past(acc_l_q) >= $past(opnd))) // RULE5
      else $error("subtract carry is not the inverted borrow");
   flags_keep_a: assert property ((exec_skip || (state_q == SSSWP_ST_EXEC
      && op_q == SSSWP_OP_SWAP)) |=> !flags_we && $stable(flags_out)) // RULE6
      else $error("skip or swap touched the flags");
   sub_to_mem_a: assert property (exec_sub && op_q == SSSWP_OP_SUB_MEM
      |=> mem_wr && !acc_we && mem_wdata == $past(acc_l_q) - $past(mem_rdata)) // RULE7
      else $error("subtract to memory wrote a wrong byte");
   sub_imm_a: assert property (state_q == SSSWP_ST_IDLE && op_valid
      && op_code == SSSWP_OP_SUB_IMM |=> ##1 acc_we
      && acc_wdata == $past(acc_in, 2) - $past(op_imm, 2) && !mem_rd) // RULE8
      else $error("immediate subtract gave a wrong accumulator");
   swap_write_a: assert property (state_q == SSSWP_ST_EXEC && op_q == SSSWP_OP_SWAP
      |=> mem_wr && mem_wdata == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])}) // RULE10
      else $error("swap wrote a wrong byte");
   sub_zero_a: assert property (exec_sub |=> flags_out[FLG_ZERO]
      == ($past(acc_l_q) == $past(opnd))) // RULE11
      else $error("subtract zero flag wrong");
endmodule : ssswp_datapath
`default_nettype wire

// ==== test/tb.sv ====
// self-checking bench for the subtract, skip and swap datapath
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
   $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb import ssswp_pkg::*;;
   typedef struct packed {
      logic acc_we, mem_wr, flags_we, skip, is_skip, rd;
      logic [DATA_W-1:0] acc_d, mem_d;
      logic [FLAG_W-1:0] flg;
      logic [ADDR_W-1:0] addr;
   } ssswp_note_t;
   logic core_clk, rst_n, op_valid, op_busy, op_done, mem_rd, mem_wr, acc_we, flags_we;
   logic skip_req;
   logic rd_seen = 1'b0;
   ssswp_op_t op_code;
   logic [ADDR_W-1:0] op_addr, mem_addr;
   logic [DATA_W-1:0] op_imm, acc_in, mem_wdata, acc_wdata, mem_val;
   logic [DATA_W-1:0] mem_rdata = 8'h00;
   logic [FLAG_W-1:0] flags_out;
   ssswp_note_t notes[$];
   int n_mismatch = 0;
   int checks_done = 0;
   logic [DATA_W-1:0] pa[6] = '{8'h00, 8'h05, 8'h03, 8'h80, 8'h7f, 8'h10};
   logic [DATA_W-1:0] pm[6] = '{8'h00, 8'h05, 8'h04, 8'h01, 8'hff, 8'h01};

   ssswp_datapath uut (.core_clk(core_clk), .rst_n(rst_n), .op_valid(op_valid),
      .op_code(op_code), .op_addr(op_addr), .op_imm(op_imm), .acc_in(acc_in),
      .op_busy(op_busy), .op_done(op_done), .mem_rd(mem_rd), .mem_wr(mem_wr),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .acc_we(acc_we),
      .acc_wdata(acc_wdata), .flags_we(flags_we), .flags_out(flags_out), .skip_req(skip_req));

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // memory byte valid only in the cycle after a read, toggling garbage otherwise
   always @(posedge core_clk) rd_seen <= mem_rd;
   always @(negedge core_clk) mem_rdata <= rd_seen ? mem_val : ~mem_rdata;

   function automatic logic [FLAG_W-1:0] sub_flags(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] d;
      logic [FLAG_W-1:0] f;
      d = {1'b0, a} - {1'b0, b};
      f = '0;
      f[FLG_CARRY] = ~d[8];
      f[FLG_AUX] = (a[3:0] >= b[3:0]);
      f[FLG_ZERO] = (d[7:0] == 8'h00);
      f[FLG_OVF] = (a[7] != b[7]) && (d[7] != a[7]);
      f[FLG_SCMP] = d[7] ^ f[FLG_OVF];
      f[FLG_CZERO] = f[FLG_ZERO];
      return f;
   endfunction : sub_flags

   task finish_test;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : finish_test

   task automatic run_op(input ssswp_op_t op, input logic [7:0] a, input logic [7:0] m);
      ssswp_note_t n;
      logic [7:0] d;
      int i;
      n = '0;
      n.rd = (op != SSSWP_OP_SUB_IMM);
      d = a - m;
      n.addr = 8'($urandom);
      case (op)
         SSSWP_OP_SKIP_NZ: begin
            n.mem_wr = 1'b1;
            n.mem_d = m;
            n.skip = (m != 8'h00);
            n.is_skip = 1'b1;
         end
         SSSWP_OP_SUB_MEM: begin
            n.mem_wr = 1'b1;
            n.mem_d = d;
            n.flags_we = 1'b1;
         end
         SSSWP_OP_SWAP: begin
            n.mem_wr = 1'b1;
            n.mem_d = {m[3:0], m[7:4]};
         end
         default: begin
            n.acc_we = 1'b1;
            n.acc_d = d;
            n.flags_we = 1'b1;
         end
      endcase
      if (n.flags_we) n.flg = sub_flags(a, m);
      notes.push_back(n);
      mem_val = (op == SSSWP_OP_SUB_IMM) ? ~m : m;
      op_code = op;
      op_addr = n.addr;
      op_imm = (op == SSSWP_OP_SUB_IMM) ? m : ~m;
      acc_in = a;
      op_valid = 1'b1;
      // held one more cycle while busy: that second strobe must be ignored
      repeat (2) @(negedge core_clk);
      op_valid = 1'b0;
      for (i = 0; i < 20 && notes.size() != 0; i++) @(negedge core_clk);
      if (notes.size() != 0) begin
         n_mismatch++;
         finish_test;
      end
      @(negedge core_clk);
      for (i = 0; i < 20 && op_busy !== 1'b0; i++) @(negedge core_clk);
      if (op_busy !== 1'b0) begin
         n_mismatch++;
         finish_test;
      end
   endtask : run_op

   initial begin
      ssswp_note_t n;
      int rd_cnt;
      logic [FLAG_W-1:0] last_flg;
      rd_cnt = 0;
      last_flg = FLAG_RST;
      forever begin
         @(posedge core_clk);
         #1;
         if (mem_rd === 1'b1) rd_cnt++;
         if (op_done === 1'b1) begin
            if (notes.size() == 0) begin
               n_mismatch++;
               $display("wrong value op_done exp 0 got 1");
            end else begin
               n = notes.pop_front();
               `CHK("skip_req", n.skip, skip_req)
               `CHK("mem_wr", n.mem_wr, mem_wr)
               `CHK("acc_we", n.acc_we, acc_we)
               `CHK("flags_we", n.flags_we, flags_we)
               if (n.mem_wr) `CHK("mem_wdata", n.mem_d, mem_wdata)
               if (n.mem_wr) `CHK("mem_addr", n.addr, mem_addr)
               if (n.acc_we) `CHK("acc_wdata", n.acc_d, acc_wdata)
               if (n.flags_we) `CHK("flags_out", n.flg, flags_out)
               else `CHK("flags_out", last_flg, flags_out)
               if (n.flags_we) last_flg = n.flg;
               `CHK("mem_rd", n.rd, rd_cnt)
               // only the skip test keeps busy through its done cycle
               `CHK("op_busy", n.is_skip, op_busy)
               rd_cnt = 0;
               @(posedge core_clk);
               #1;
               if (mem_rd === 1'b1) rd_cnt++;
               `CHK("op_busy", 1'b0, op_busy)
            end
         end
      end
   end

   initial begin
      rst_n = 1'b0;
      op_valid = 1'b0;
      op_code = SSSWP_OP_SKIP_NZ;
      op_addr = 8'h00;
      op_imm = 8'h00;
      acc_in = 8'h00;
      mem_val = 8'h00;
      void'($urandom(66));
      repeat (10) @(negedge core_clk);
      rst_n = 1'b1;
      repeat (3) @(negedge core_clk);
      // boundary pairs: zero, equal, borrow, signed overflow, nibble borrow
      for (int k = 0; k < 5; k++) begin
         for (int p = 0; p < 6; p++) run_op(ssswp_op_t'(k), pa[p], pm[p]);
      end
      for (int r = 0; r < 60; r++) begin
         run_op(ssswp_op_t'($urandom % 5), 8'($urandom), 8'($urandom));
      end
      repeat (4) @(negedge core_clk);
      finish_test;
   end
endmodule : tb
`undef CHK
`default_nettype wire
